// ===== logic/rtc_serial_pkg.sv
// Shared constants and types for the three-wire serial port of the clock.
// Assumes a single 20 MHz system clock; nothing here is clocked.
package rtc_serial_pkg;

    // ------------------------------------------------------------------
    // Command byte layout
    // ------------------------------------------------------------------
    localparam int         BYTE_W       = 8;
    localparam int         BIT_CNT_W    = 3;
    localparam int         IDX_W        = 4;
    localparam int         CMD_DIR_BIT  = 7;
    localparam int         SA_HI        = 6;
    localparam int         SA_LO        = 4;
    localparam int         IDX_HI       = 3;
    localparam logic [2:0] SA_VALID     = 3'h1;
    localparam logic [2:0] BIT_LAST     = 3'h7;
    localparam logic [3:0] IDX_RESET    = 4'h0;
    localparam logic [7:0] BYTE_RESET   = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint     CLK_HZ       = 64'd20_000_000;
    localparam longint     WD_TIME_MS   = 64'd1000;
    localparam longint     WD_CYCLES    = (WD_TIME_MS * CLK_HZ) / 64'd1000;
    localparam int         WD_CNT_W     = 26;
    localparam int         SYNC_W       = 3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LINK_IDLE   = 3'b000,
        LINK_CMD    = 3'b001,
        LINK_WRITE  = 3'b010,
        LINK_READ   = 3'b011,
        LINK_IGNORE = 3'b100,
        LINK_ABORT  = 3'b101
    } link_state_t;

    typedef struct packed {
        logic chip_enable;
        logic serial_clock;
        logic serial_data_in;
    } link_pins_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] index;
        logic [7:0] data;
    } reg_access_t;

endpackage : rtc_serial_pkg

// ===== logic/pin_sync.sv
// Two-stage synchroniser for the link pins.
// Assumes pins are asynchronous to ref_clk; only stage two is visible.
`timescale 1ns/1ns
module pin_sync (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst_b,
    input  wire logic                          clk_en,
    // Pins in, synchronised copy out
    input  wire rtc_serial_pkg::link_pins_t    pins,
    output rtc_serial_pkg::link_pins_t         pins_sync
);

    rtc_serial_pkg::link_pins_t stage1_q;

    // Stage one feeds stage two and nothing else
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_q  <= '0;
            pins_sync <= '0;
        end else if (clk_en) begin
            stage1_q  <= pins;
            pins_sync <= stage1_q;
        end
    end

endmodule : pin_sync

// ===== logic/access_watchdog.sv
// Interface watchdog: counts system clocks while an access is running.
// Assumes run drops when the access ends; expire pulses every WD_CYCLES clocks while run stays high.
`timescale 1ns/1ns
module access_watchdog #(
    parameter longint WD_CYCLES = rtc_serial_pkg::WD_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    // Control and event
    input  wire logic run,
    output logic      expire
);

    localparam logic [rtc_serial_pkg::WD_CNT_W-1:0] LIMIT =
        rtc_serial_pkg::WD_CNT_W'(WD_CYCLES - 64'd1);

    logic [rtc_serial_pkg::WD_CNT_W-1:0] count_q;

    // Count up while running; restart whenever run is low
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
            expire  <= 1'b0;
        end else if (clk_en) begin
            expire  <= run && (count_q == LIMIT);
            if (!run || count_q == LIMIT) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

endmodule : access_watchdog

// ===== logic/rtc_serial_port.sv
// Three-wire serial slave port of the clock/calendar: command decode,
// register access stream, output shifter, freeze and watchdog abort.
// Assumes a register file on ref_clk that returns read data for
// reg_access.index combinationally, and link pins asynchronous to ref_clk.
`timescale 1ns/1ns

// Summary of operation
// - Whole bytes, most significant bit first
// - Chip enable low resets the interface
// - Data in sampled on rising clock
// - Data out changes on falling clock
// - Data out released when not reading
// - First framed byte is command byte
// - Sampled bit shifted in on falling clock
// - Command bit 7: zero write, one read
// - Subaddress must be 001, else ignore
// - Command low nibble is start index
// - Index increments per byte, wraps
// - Timekeeping frozen during an access
// - Stale access aborted, counting resumes
// - After abort, wait for enable low
// - Abort between one and two seconds
// - Abort loses one second, uncompensated
module rtc_serial_port #(
    parameter longint WD_CYCLES = rtc_serial_pkg::WD_CYCLES
) (
    // Clock, reset, enable
    input  wire logic                         ref_clk,
    input  wire logic                         rst_b,
    input  wire logic                         clk_en,
    // Link pins
    input  wire logic                         chip_enable,
    input  wire logic                         serial_clock,
    input  wire logic                         serial_data_in,
    output logic                              serial_data_out,
    output logic                              serial_data_out_oe,
    // Register file side
    output rtc_serial_pkg::reg_access_t       reg_access,
    input  wire logic [7:0]                   reg_rd_data,
    // Timekeeping side
    output logic                              time_freeze,
    output logic                              access_aborted
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Index step with natural wrap from Fh to 0h
    function automatic logic [3:0] next_index(input logic [3:0] idx);
        next_index = idx + 4'h1;
    endfunction : next_index

    // Byte as it stands after the last bit, MSB arrived first
    function automatic logic [7:0] full_byte(input logic [7:0] sh, input logic b);
        full_byte = {sh[6:0], b};
    endfunction : full_byte

    // ------------------------------------------------------------------
    // Reset release and pin synchronisation
    // ------------------------------------------------------------------
    logic                          rst_meta_q;
    logic                          rst_sync_q;
    rtc_serial_pkg::link_pins_t    pins;
    rtc_serial_pkg::link_pins_t    pins_s;

    // Reset asserts at once, releases after two edges
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign pins = '{chip_enable:    chip_enable,
                    serial_clock:   serial_clock,
                    serial_data_in: serial_data_in};

    pin_sync u_pin_sync (
        .ref_clk   (ref_clk),
        .rst_b     (rst_sync_q),
        .clk_en    (clk_en),
        .pins      (pins),
        .pins_sync (pins_s)
    );

    // ------------------------------------------------------------------
    // Link clock edges
    // ------------------------------------------------------------------
    logic sclk_prev_q;
    logic rise_ev;
    logic fall_ev;
    logic cs_s;

    assign cs_s    = pins_s.chip_enable;
    assign rise_ev = cs_s && pins_s.serial_clock && !sclk_prev_q;
    assign fall_ev = cs_s && !pins_s.serial_clock && sclk_prev_q;

    // Previous sampled clock level for edge finding
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            sclk_prev_q <= 1'b0;
        end else if (clk_en) begin
            sclk_prev_q <= pins_s.serial_clock;
        end
    end

    // ------------------------------------------------------------------
    // Bit capture and byte assembly
    // ------------------------------------------------------------------
    logic [2:0] bit_cnt_q;
    logic       sample_q;
    logic [7:0] shift_q;
    logic       byte_done;
    logic       last_rise;
    logic [7:0] rx_byte;

    assign byte_done = fall_ev && (bit_cnt_q == rtc_serial_pkg::BIT_LAST);
    assign last_rise = rise_ev && (bit_cnt_q == rtc_serial_pkg::BIT_LAST);
    assign rx_byte   = full_byte(shift_q, sample_q);

    // Sample on rise, move inward on the following fall
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            bit_cnt_q <= '0;
            sample_q  <= 1'b0;
            shift_q   <= rtc_serial_pkg::BYTE_RESET;
        end else if (clk_en) begin
            if (!cs_s) begin
                bit_cnt_q <= '0;
                shift_q   <= rtc_serial_pkg::BYTE_RESET;
            end else begin
                if (rise_ev) begin
                    sample_q <= pins_s.serial_data_in;
                end
                if (fall_ev) begin
                    shift_q   <= rx_byte;
                    bit_cnt_q <= bit_cnt_q + 3'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Transfer state
    // ------------------------------------------------------------------
    rtc_serial_pkg::link_state_t state_q;
    logic                        wd_expire;
    logic                        cmd_ok;

    assign cmd_ok = rx_byte[rtc_serial_pkg::SA_HI:rtc_serial_pkg::SA_LO]
                    == rtc_serial_pkg::SA_VALID;

    // Framing by chip enable; the first byte is always the command
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= rtc_serial_pkg::LINK_IDLE;
        end else if (clk_en) begin
            if (!cs_s) begin
                state_q <= rtc_serial_pkg::LINK_IDLE;
            end else begin
                unique case (state_q)
                    rtc_serial_pkg::LINK_IDLE: begin
                        state_q <= rtc_serial_pkg::LINK_CMD;
                    end
                    rtc_serial_pkg::LINK_CMD: begin
                        if (byte_done) begin
                            if (!cmd_ok) begin
                                state_q <= rtc_serial_pkg::LINK_IGNORE;
                            end else if (rx_byte[rtc_serial_pkg::CMD_DIR_BIT]) begin
                                state_q <= rtc_serial_pkg::LINK_READ;
                            end else begin
                                state_q <= rtc_serial_pkg::LINK_WRITE;
                            end
                        end
                    end
                    rtc_serial_pkg::LINK_WRITE,
                    rtc_serial_pkg::LINK_READ: begin
                        if (wd_expire) begin
                            state_q <= rtc_serial_pkg::LINK_ABORT;
                        end
                    end
                    rtc_serial_pkg::LINK_IGNORE,
                    rtc_serial_pkg::LINK_ABORT: begin
                        state_q <= state_q;
                    end
                    default: begin
                        state_q <= rtc_serial_pkg::LINK_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Watchdog and freeze
    // ------------------------------------------------------------------
    logic access_active;

    assign access_active = (state_q == rtc_serial_pkg::LINK_WRITE) ||
                           (state_q == rtc_serial_pkg::LINK_READ);

    // Runs from the valid command onward; restarts each access
    access_watchdog #(
        .WD_CYCLES (WD_CYCLES)
    ) u_watchdog (
        .ref_clk (ref_clk),
        .rst_b   (rst_sync_q),
        .clk_en  (clk_en),
        .run     (access_active),
        .expire  (wd_expire)
    );

    // Freeze follows the access; the second spent here is simply lost
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            time_freeze    <= 1'b0;
            access_aborted <= 1'b0;
        end else if (clk_en) begin
            time_freeze    <= access_active && !wd_expire && cs_s;
            access_aborted <= cs_s && (wd_expire ||
                              state_q == rtc_serial_pkg::LINK_ABORT);
        end
    end

    // ------------------------------------------------------------------
    // Register index and access strobes
    // ------------------------------------------------------------------
    logic in_write;
    logic in_read;
    logic read_load;

    assign in_write  = (state_q == rtc_serial_pkg::LINK_WRITE) && !wd_expire;
    assign in_read   = (state_q == rtc_serial_pkg::LINK_READ) && !wd_expire;
    // Read data is fetched on the fall that ends a valid read command or a read byte
    assign read_load = byte_done && ((state_q == rtc_serial_pkg::LINK_READ) ||
                       (state_q == rtc_serial_pkg::LINK_CMD && cmd_ok &&
                        rx_byte[rtc_serial_pkg::CMD_DIR_BIT]));

    // Index is staged at the last rise so read data is ready by the fall
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            reg_access <= '{wr: 1'b0, rd: 1'b0,
                            index: rtc_serial_pkg::IDX_RESET,
                            data: rtc_serial_pkg::BYTE_RESET};
        end else if (clk_en) begin
            reg_access.wr <= 1'b0;
            reg_access.rd <= 1'b0;
            if (last_rise && state_q == rtc_serial_pkg::LINK_CMD) begin
                reg_access.index <= {shift_q[2:0], pins_s.serial_data_in};
            end else if (last_rise && in_read) begin
                reg_access.index <= next_index(reg_access.index);
            end
            if (byte_done && in_write) begin
                reg_access.wr   <= 1'b1;
                reg_access.data <= rx_byte;
            end
            if (read_load && (in_read || state_q == rtc_serial_pkg::LINK_CMD)) begin
                reg_access.rd <= 1'b1;
            end
            if (reg_access.wr) begin
                reg_access.index <= next_index(reg_access.index);
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------------
    logic [7:0] tx_q;

    // Output moves only on falls; released outside a read
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            tx_q               <= rtc_serial_pkg::BYTE_RESET;
            serial_data_out    <= 1'b0;
            serial_data_out_oe <= 1'b0;
        end else if (clk_en) begin
            if (!cs_s || wd_expire || !(in_read || read_load)) begin
                serial_data_out_oe <= 1'b0;
            end else if (read_load) begin
                tx_q               <= {reg_rd_data[6:0], 1'b0};
                serial_data_out    <= reg_rd_data[7];
                serial_data_out_oe <= 1'b1;
            end else if (fall_ev) begin
                tx_q            <= {tx_q[6:0], 1'b0};
                serial_data_out <= tx_q[7];
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_q || !clk_en);

    sequence s_cmd_bad;
        state_q == rtc_serial_pkg::LINK_CMD && byte_done && !cmd_ok;
    endsequence

    sequence s_write_byte;
        byte_done && in_write;
    endsequence

    property p_cs_low_resets;
        !cs_s |=> state_q == rtc_serial_pkg::LINK_IDLE && bit_cnt_q == 3'h0;
    endproperty
    a_cs_low_resets: assert property (p_cs_low_resets)
        else $error("interface not reset while enable low");

    property p_sample_on_rise;
        rise_ev |=> sample_q == $past(pins_s.serial_data_in);
    endproperty
    a_sample_on_rise: assert property (p_sample_on_rise)
        else $error("input not sampled on rising edge");

    property p_out_stable_on_rise;
        rise_ev && !read_load |=> $stable(serial_data_out);
    endproperty
    a_out_stable_on_rise: assert property (p_out_stable_on_rise)
        else $error("output changed on rising edge");

    property p_shift_on_fall;
        fall_ev |=> shift_q[0] == $past(sample_q);
    endproperty
    a_shift_on_fall: assert property (p_shift_on_fall)
        else $error("sampled bit not shifted on falling edge");

    property p_bad_sa_silent;
        s_cmd_bad |=> (!serial_data_out_oe && !reg_access.wr &&
                       !reg_access.rd) [*4];
    endproperty
    a_bad_sa_silent: assert property (p_bad_sa_silent)
        else $error("bad subaddress access not ignored");

    property p_write_then_step;
        s_write_byte |=> reg_access.wr ##1
                         reg_access.index == $past(reg_access.index) + 4'h1;
    endproperty
    a_write_then_step: assert property (p_write_then_step)
        else $error("write strobe or index step missing");

    property p_freeze_only_in_access;
        time_freeze |-> $past(access_active);
    endproperty
    a_freeze_only_in_access: assert property (p_freeze_only_in_access)
        else $error("freeze outside an access");

    property p_abort_releases;
        wd_expire && cs_s |=> !time_freeze && access_aborted && !serial_data_out_oe
                           ##1 state_q == rtc_serial_pkg::LINK_ABORT || !cs_s;
    endproperty
    a_abort_releases: assert property (p_abort_releases)
        else $error("watchdog abort did not release the interface");

endmodule : rtc_serial_port

// ===== bench/host_master.sv
// Host model: serial bus master driving enable, link clock and data in.
// Assumes a 20 MHz ref_clk; every pin changes on its falling edge.
`timescale 1ns/1ns
module host_master (
    // Clock
    input  wire logic ref_clk,
    // Link pins
    output logic      chip_enable,
    output logic      serial_clock,
    output logic      serial_data_in,
    input  wire logic serial_data_out
);
    // ------------------------------------------------------------
    // Pin levels and link timing
    // ------------------------------------------------------------
    initial begin
        chip_enable    = 1'b0;
        serial_clock   = 1'b0; // Stands still outside frames
        serial_data_in = 1'b0; // Never floated
    end

    // One 200 ns link clock phase
    task automatic phase();
        repeat (4) @(negedge ref_clk);
    endtask : phase

    // Open a frame; the next byte is the command byte
    task automatic start();
        @(negedge ref_clk);
        chip_enable = 1'b1;
        phase();
    endtask : start

    // Close a frame so the port resets before the next one
    task automatic stop();
        phase();
        chip_enable    = 1'b0;
        serial_data_in = ~serial_data_in; // Still driven, old value gone
        phase();
        phase();
    endtask : stop

    // Shift n bits out MSB first; sample return data at each rise
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            serial_data_in = tx[i];
            phase();
            serial_clock = 1'b1;
            rx[i]        = serial_data_out;
            phase();
            serial_clock = 1'b0;
        end
    endtask : bits
endmodule : host_master

// ===== bench/rtc_three_wire_serial_port_bench.sv
// Self-checking bench for the serial port with a host model and a
// register file model; watchdog shortened to 200 cycles.
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module rtc_three_wire_serial_port_bench;
    // ------------------------------------------------------------
    // Signals and models
    // ------------------------------------------------------------
    localparam longint WD = 200;
    logic ref_clk, rst_b, clk_en, chip_enable, serial_clock, serial_data_in;
    logic serial_data_out, serial_data_out_oe, time_freeze, access_aborted, sdo_wire;
    rtc_serial_pkg::reg_access_t reg_access;
    logic [7:0]  reg_rd_data, r, keep;
    logic [7:0]  regs [16];
    int          failures, compares, wr_cnt, rd_cnt, n;
    logic        oe_seen;

    // Pin is high-Z unless enabled, so a wrong enable shows as z
    assign sdo_wire    = serial_data_out_oe ? serial_data_out : 1'bz;
    assign reg_rd_data = regs[reg_access.index];

    // Register file and drive monitor
    always @(posedge ref_clk) begin
        if (serial_data_out_oe === 1'b1) oe_seen = 1'b1;
        if (reg_access.rd === 1'b1) rd_cnt++;
        if (reg_access.wr === 1'b1) begin
            regs[reg_access.index] = reg_access.data;
            wr_cnt++;
        end
    end

    rtc_serial_port #(.WD_CYCLES(WD)) u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .chip_enable(chip_enable),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
        .reg_access(reg_access), .reg_rd_data(reg_rd_data),
        .time_freeze(time_freeze), .access_aborted(access_aborted));
    host_master u_host (
        .ref_clk(ref_clk), .chip_enable(chip_enable), .serial_clock(serial_clock),
        .serial_data_in(serial_data_in), .serial_data_out(sdo_wire));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic xfer(input logic [7:0] tx);
        u_host.bits(tx, 8, r);
    endtask : xfer

    task automatic frame(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
        u_host.start();
        xfer(cmd);
        xfer(d0);
        xfer(d1);
        u_host.stop();
    endtask : frame

    task automatic tally_and_finish();
        if (failures == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Write two bytes, then a write that wraps the index
    task automatic t_write();
        u_host.start();
        xfer(8'h15);
        repeat (6) @(negedge ref_clk);
        `CHK(time_freeze, 1'b1)
        // Enable low longer than the watchdog span: nothing may move
        clk_en = 1'b0;
        repeat (300) @(negedge ref_clk);
        `CHK(time_freeze, 1'b1)
        `CHK(access_aborted, 1'b0)
        clk_en = 1'b1;
        xfer(8'h45);
        xfer(8'h10);
        `CHK(serial_data_out_oe, 1'b0)
        u_host.stop();
        `CHK(time_freeze, 1'b0)
        `CHK(regs[5], 8'h45)
        `CHK(regs[6], 8'h10)
        frame(8'h1F, 8'hA1, 8'hB2);
        `CHK(regs[15], 8'hA1)
        `CHK(regs[0], 8'hB2)
    endtask : t_write

    // Read across the top index; data changes on falls, taken on rises
    task automatic t_read();
        @(negedge ref_clk);
        n        = rd_cnt;
        regs[14] = 8'h3C;
        regs[15] = 8'hC3;
        regs[0]  = 8'h96;
        u_host.start();
        xfer(8'h9E);
        xfer(8'h00);
        `CHK(r, 8'h3C)
        `CHK(serial_data_out_oe, 1'b1)
        xfer(8'hFF);
        `CHK(r, 8'hC3)
        xfer(8'h00);
        `CHK(r, 8'h96)
        u_host.stop();
        `CHK(serial_data_out_oe, 1'b0)
        `CHK(rd_cnt - n, 4)
    endtask : t_read

    // Every wrong subaddress code, one direction each (bit 7 = code bit 0): nothing happens
    task automatic t_bad_sub();
        logic [2:0] s;
        for (int i = 0; i < 8; i++) begin
            s = i[2:0];
            if (s != 3'h1) begin
                keep    = regs[3];
                n       = wr_cnt;
                oe_seen = 1'b0;
                frame({s[0], s, 4'h3}, 8'h5A, 8'hA5);
                `CHK(wr_cnt, n)
                `CHK(oe_seen, 1'b0)
                `CHK(regs[3], keep)
            end
        end
    endtask : t_bad_sub

    // Half bytes dropped by enable low must not skew the next frame
    task automatic t_partial();
        u_host.start();
        u_host.bits(8'h9F, 4, r);
        u_host.stop();
        frame(8'h17, 8'h5E, 8'h6F);
        `CHK(regs[7], 8'h5E)
        `CHK(regs[8], 8'h6F)
        keep = regs[9];
        u_host.start();
        xfer(8'h19);
        u_host.bits(8'hFF, 5, r);
        u_host.stop();
        `CHK(regs[9], keep)
    endtask : t_partial

    // Stale access aborted inside the window, locked until enable low
    task automatic t_watchdog();
        u_host.start();
        xfer(8'h12);
        n = 0;
        while (access_aborted !== 1'b1 && n < 1000) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK((n >= WD) && (n <= 2 * WD), 1'b1)
        `CHK(time_freeze, 1'b0)
        keep = regs[2];
        xfer(8'h77);
        `CHK(regs[2], keep)
        u_host.stop();
        `CHK(access_aborted, 1'b0)
    endtask : t_watchdog

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst_b  = 1'b0;
        clk_en = 1'b1;
        for (int i = 0; i < 16; i++) regs[i] = 8'h00;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (5) @(negedge ref_clk);
        t_write();
        t_read();
        t_bad_sub();
        t_partial();
        t_watchdog();
        tally_and_finish();
    end

    // Run needs about 3200 cycles; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        tally_and_finish();
    end
endmodule : rtc_three_wire_serial_port_bench
